// ===== design/seg_addr_pkg.sv
// constants and types for the segment address generator
// Notes on behaviour
// R1 - every memory access uses a 20-bit physical byte address, 0 to 0FFFFFH
// R2 - logical address is unsigned 16-bit segment base plus 16-bit offset
// R3 - segments start on 16-byte boundaries: physical equals base times sixteen plus offset
// R4 - carry out of bit 19 is dropped, addresses wrap in 20 bits
// R5 - instruction fetch always uses code segment and fetch offset pointer
// R6 - stack operations always use stack segment and stack top offset
// R7 - operands default to data segment, override may pick code, extra or stack
// R8 - string source defaults to data segment, overridable, offset from source index
// R9 - string destination always uses extra segment and destination index, no override
// R10 - frame base pointer references default to stack segment, overridable to others
// R11 - an override prefix redirects overridable references to the named segment
// R12 - after each string element both indices step by one byte or word
// R13 - direction flag set decrements string indices, clear increments them
// R14 - stack elements are 16 bits, one word per push or pop
// R15 - push lowers stack top offset by 2 before writing the word
// R16 - pop reads the stack top word, then raises the offset by two
// R17 - stack offsets wrap within the 64 Kbyte segment
// R18 - stack operations never move elements; only the offset changes the top
// R19 - four segment registers give four simultaneously addressable segments
// R20 - software keeps programs out of 0H to 3FFH
// R21 - execution begins at 0FFFF0H after reset
// R22 - reset loads code segment 0FFFFH, fetch offset 0000H, others zero
// R23 - software does not use I/O addresses 0F8H through 0FFH
package seg_addr_pkg;
  localparam int unsigned phys_w = 20;
  localparam logic [15:0] code_seg_reset = 16'hffff;
  localparam logic [15:0] fetch_off_reset = 16'h0000;
  localparam logic [15:0] data_seg_reset = 16'h0000;
  localparam logic [15:0] word_step = 16'h0002;
  localparam logic [15:0] byte_step = 16'h0001;
  localparam logic [19:0] vector_top = 20'h003ff;
  localparam logic [19:0] reset_area_base = 20'hffff0;
  localparam logic [15:0] io_resv_lo = 16'h00f8;
  localparam logic [15:0] io_resv_hi = 16'h00ff;

  // segment register index
  typedef enum logic [1:0] {
    seg_extra = 2'b00,
    seg_code = 2'b01,
    seg_stack = 2'b10,
    seg_data = 2'b11
  } seg_sel_t;

  // kind of memory reference
  typedef enum logic [2:0] {
    ref_fetch = 3'h0,
    ref_stack = 3'h1,
    ref_operand = 3'h2,
    ref_str_src = 3'h3,
    ref_str_dst = 3'h4,
    ref_frame = 3'h5
  } ref_kind_t;

  // stack / string pointer operation
  typedef enum logic [1:0] {
    pop_none = 2'b00,
    pop_push = 2'b01,
    pop_pop = 2'b11,
    pop_string = 2'b10
  } ptr_op_t;
endpackage : seg_addr_pkg

// ===== design/seg_reg_file.sv
// four segment base registers with registered read port
`timescale 1ns/1ps
`default_nettype none
module seg_reg_file (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // write port
  input wire logic wr_en,
  input wire seg_addr_pkg::seg_sel_t wr_sel,
  input wire logic [15:0] wr_data,
  // registered read port
  input wire seg_addr_pkg::seg_sel_t rd_sel,
  output logic [15:0] rd_data,
  // code segment for fetch path
  output logic [15:0] code_base
);
  logic [15:0] regs [4];
  logic [15:0] next_regs [4];
  logic [15:0] next_rd_data;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_regs[i] = regs[i];
    end
    if (wr_en) begin
      next_regs[wr_sel] = wr_data;
    end
    next_rd_data = next_regs[rd_sel];
  end

  // four live segments at once, see R19
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_seg
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          regs[g] <= (g == 1) ? seg_addr_pkg::code_seg_reset
                              : seg_addr_pkg::data_seg_reset; // see R22
        end else begin
          regs[g] <= next_regs[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= seg_addr_pkg::data_seg_reset;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  assign code_base = regs[1];
endmodule : seg_reg_file
`default_nettype wire

// ===== design/seg_addr_gen.sv
// segment selection, physical address and pointer stepping
`timescale 1ns/1ps
`default_nettype none
module seg_addr_gen (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // segment register load
  input wire logic seg_wr,
  input wire seg_addr_pkg::seg_sel_t seg_wr_sel,
  input wire logic [15:0] seg_wr_data,
  // reference request from execution unit
  input wire logic req,
  input wire seg_addr_pkg::ref_kind_t ref_kind,
  input wire logic override_valid,
  input wire seg_addr_pkg::seg_sel_t override_seg,
  input wire logic [15:0] computed_operand_offset,
  input wire seg_addr_pkg::ptr_op_t ptr_op,
  input wire logic word_elem,
  input wire logic string_direction_flag,
  // pointer loads
  input wire logic fetch_advance,
  input wire logic [15:0] fetch_step,
  input wire logic fetch_load,
  input wire logic [15:0] fetch_load_value,
  input wire logic stack_load,
  input wire logic [15:0] stack_load_value,
  input wire logic idx_load,
  input wire logic [15:0] src_idx_load_value,
  input wire logic [15:0] dst_idx_load_value,
  // i/o address check
  input wire logic [15:0] io_addr,
  // outputs to bus interface
  output logic addr_valid,
  output logic [19:0] phys_addr,
  output logic low_vector_hit,
  output logic reset_area_hit,
  output logic io_reserved_hit,
  // pointer state
  output logic [15:0] fetch_offset_pointer,
  output logic [15:0] stack_top_offset,
  output logic [15:0] string_src_index,
  output logic [15:0] string_dest_index
);
  // ****************************************
  // segment selection
  // ****************************************
  seg_addr_pkg::seg_sel_t sel;
  logic [15:0] offset;
  logic [15:0] seg_base;
  logic [15:0] code_base;
  logic [15:0] stk_pre;

  // the stack pointer is pre-decremented for push so the write hits the new top
  always_comb begin
    stk_pre = (ptr_op == seg_addr_pkg::pop_push)
            ? 16'(stack_top_offset - seg_addr_pkg::word_step) // see R15
            : stack_top_offset; // see R16
  end

  always_comb begin
    sel = seg_addr_pkg::seg_data;
    offset = computed_operand_offset;
    case (ref_kind)
      seg_addr_pkg::ref_fetch: begin
        sel = seg_addr_pkg::seg_code; // see R5
        offset = fetch_offset_pointer;
      end
      seg_addr_pkg::ref_stack: begin
        sel = seg_addr_pkg::seg_stack; // see R6
        offset = stk_pre; // see R14
      end
      seg_addr_pkg::ref_operand: begin
        sel = override_valid ? override_seg : seg_addr_pkg::seg_data; // see R7 R11
      end
      seg_addr_pkg::ref_str_src: begin
        sel = override_valid ? override_seg : seg_addr_pkg::seg_data; // see R8 R11
        offset = string_src_index;
      end
      seg_addr_pkg::ref_str_dst: begin
        sel = seg_addr_pkg::seg_extra; // see R9
        offset = string_dest_index;
      end
      seg_addr_pkg::ref_frame: begin
        sel = override_valid ? override_seg : seg_addr_pkg::seg_stack; // see R10 R11
      end
      default: begin
        sel = seg_addr_pkg::seg_data;
      end
    endcase
  end

  // read data is registered, so the offset is delayed one cycle to match
  seg_reg_file u_segs (
    .clk(clk),
    .nrst(nrst),
    .wr_en(seg_wr),
    .wr_sel(seg_wr_sel),
    .wr_data(seg_wr_data),
    .rd_sel(sel),
    .rd_data(seg_base),
    .code_base(code_base)
  );

  // ****************************************
  // address pipeline
  // ****************************************
  logic req_q;
  logic [15:0] offset_q;
  logic next_req_q;
  logic [15:0] next_offset_q;
  logic [19:0] sum;

  always_comb begin
    next_req_q = req;
    next_offset_q = offset;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_q <= 1'b0;
      offset_q <= 16'h0000;
    end else begin
      req_q <= next_req_q;
      offset_q <= next_offset_q;
    end
  end

  // base times sixteen plus offset, carry past bit 19 dropped
  always_comb begin
    sum = 20'({seg_base, 4'h0} + {4'h0, offset_q}); // see R2 R3 R4
  end

  logic next_addr_valid;
  logic [19:0] next_phys_addr;
  logic next_low_vector_hit;
  logic next_reset_area_hit;
  logic next_io_reserved_hit;

  always_comb begin
    next_addr_valid = req_q;
    next_phys_addr = req_q ? sum : phys_addr; // see R1
    next_low_vector_hit = req_q ? (sum <= seg_addr_pkg::vector_top) : low_vector_hit; // see R20
    next_reset_area_hit = req_q ? (sum >= seg_addr_pkg::reset_area_base) : reset_area_hit;
    next_io_reserved_hit = (io_addr >= seg_addr_pkg::io_resv_lo)
                         && (io_addr <= seg_addr_pkg::io_resv_hi); // see R23
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_valid <= 1'b0;
      phys_addr <= seg_addr_pkg::reset_area_base; // see R21
      low_vector_hit <= 1'b0;
      reset_area_hit <= 1'b1;
      io_reserved_hit <= 1'b0;
    end else begin
      addr_valid <= next_addr_valid;
      phys_addr <= next_phys_addr;
      low_vector_hit <= next_low_vector_hit;
      reset_area_hit <= next_reset_area_hit;
      io_reserved_hit <= next_io_reserved_hit;
    end
  end

  // ****************************************
  // pointer registers
  // ****************************************
  logic [15:0] next_fetch;
  logic [15:0] next_stack;
  logic [15:0] next_src;
  logic [15:0] next_dst;
  logic [15:0] elem_step;

  always_comb begin
    elem_step = word_elem ? seg_addr_pkg::word_step : seg_addr_pkg::byte_step;
    next_fetch = fetch_offset_pointer;
    next_stack = stack_top_offset;
    next_src = string_src_index;
    next_dst = string_dest_index;
    if (fetch_load) begin
      next_fetch = fetch_load_value;
    end else if (fetch_advance) begin
      next_fetch = 16'(fetch_offset_pointer + fetch_step);
    end
    // only the offset moves; stored words are untouched, see R18
    if (stack_load) begin
      next_stack = stack_load_value;
    end else if (req && ref_kind == seg_addr_pkg::ref_stack) begin
      if (ptr_op == seg_addr_pkg::pop_push) begin
        next_stack = stk_pre; // see R15 R17
      end else if (ptr_op == seg_addr_pkg::pop_pop) begin
        next_stack = 16'(stack_top_offset + seg_addr_pkg::word_step); // see R16 R17
      end
    end
    if (idx_load) begin
      next_src = src_idx_load_value;
      next_dst = dst_idx_load_value;
    end else if (req && ptr_op == seg_addr_pkg::pop_string) begin
      if (string_direction_flag) begin
        next_src = 16'(string_src_index - elem_step); // see R12 R13
        next_dst = 16'(string_dest_index - elem_step);
      end else begin
        next_src = 16'(string_src_index + elem_step); // see R12 R13
        next_dst = 16'(string_dest_index + elem_step);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fetch_offset_pointer <= seg_addr_pkg::fetch_off_reset; // see R22
      stack_top_offset <= 16'h0000;
      string_src_index <= 16'h0000;
      string_dest_index <= 16'h0000;
    end else begin
      fetch_offset_pointer <= next_fetch;
      stack_top_offset <= next_stack;
      string_src_index <= next_src;
      string_dest_index <= next_dst;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  fetch_addr_a: assert property (@(posedge clk) disable iff (!nrst) // see R5
    req && ref_kind == seg_addr_pkg::ref_fetch && !seg_wr ##1 !seg_wr |=>
    phys_addr == 20'({code_base, 4'h0} + {4'h0, $past(fetch_offset_pointer, 2)}))
    else $error("fetch address not code based");
  push_step_a: assert property (@(posedge clk) disable iff (!nrst) // see R15
    req && ref_kind == seg_addr_pkg::ref_stack && ptr_op == seg_addr_pkg::pop_push
    && !stack_load |=> stack_top_offset == 16'($past(stack_top_offset) - 16'h0002))
    else $error("push did not lower offset by two");
  pop_step_a: assert property (@(posedge clk) disable iff (!nrst) // see R16
    req && ref_kind == seg_addr_pkg::ref_stack && ptr_op == seg_addr_pkg::pop_pop
    && !stack_load |=> stack_top_offset == 16'($past(stack_top_offset) + 16'h0002))
    else $error("pop did not raise offset by two");
  stack_hold_a: assert property (@(posedge clk) disable iff (!nrst) // see R18
    !stack_load && !(req && ref_kind == seg_addr_pkg::ref_stack) |=> $stable(stack_top_offset))
    else $error("stack offset moved without stack op");
  str_dec_a: assert property (@(posedge clk) disable iff (!nrst) // see R13
    req && ptr_op == seg_addr_pkg::pop_string && string_direction_flag && !idx_load |=>
    string_dest_index == 16'($past(string_dest_index) - $past(elem_step)))
    else $error("string index not decremented");
  str_inc_a: assert property (@(posedge clk) disable iff (!nrst) // see R12
    req && ptr_op == seg_addr_pkg::pop_string && !string_direction_flag && !idx_load |=>
    string_src_index == 16'($past(string_src_index) + $past(elem_step)))
    else $error("string index not incremented");
  dst_extra_a: assert property (@(posedge clk) disable iff (!nrst) // see R9
    req && ref_kind == seg_addr_pkg::ref_str_dst |-> sel == seg_addr_pkg::seg_extra)
    else $error("string destination not extra segment");
  valid_lat_a: assert property (@(posedge clk) disable iff (!nrst) // see R1
    req |-> ##2 addr_valid)
    else $error("address not valid two cycles after request");
  override_a: assert property (@(posedge clk) disable iff (!nrst) // see R11
    req && override_valid && ref_kind == seg_addr_pkg::ref_frame |-> sel == override_seg)
    else $error("override ignored on frame reference");
endmodule : seg_addr_gen
`default_nettype wire

// ===== dv/seg_bus_sink.sv
// bus interface side model that takes the physical addresses
`timescale 1ns/1ps
`default_nettype none
module seg_bus_sink (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // address from the generator
  input wire logic addr_valid,
  input wire logic [19:0] phys_addr,
  // what was taken
  output logic [19:0] last_addr,
  output logic [15:0] seen_count
);
  // ****************************************
  // address capture
  // ****************************************
  // one capture per valid cycle, so a stretched strobe shows as extra counts
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_addr <= 20'h00000;
      seen_count <= 16'h0000;
    end else if (addr_valid) begin
      last_addr <= phys_addr;
      seen_count <= seen_count + 16'h0001;
    end
  end
  // software side keeps code out of the vector area and off ports f8..ff;
  // the bench only probes those places, never loads programs there
endmodule : seg_bus_sink
`default_nettype wire

// ===== dv/segment_address_generator_tb.sv
// self-checking testbench of the segment address generator
`timescale 1ns/1ps
`default_nettype none
module segment_address_generator_tb;
  // ****************************************
  // stimulus and observation
  // ****************************************
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic seg_wr = 1'b0;
  seg_addr_pkg::seg_sel_t wsel = seg_addr_pkg::seg_extra;
  logic [15:0] wdata = 16'h0000;
  logic req = 1'b0;
  seg_addr_pkg::ref_kind_t kind = seg_addr_pkg::ref_fetch;
  logic ovv = 1'b0;
  seg_addr_pkg::seg_sel_t ovs = seg_addr_pkg::seg_extra;
  logic [15:0] eoff = 16'h0000;
  seg_addr_pkg::ptr_op_t pop = seg_addr_pkg::pop_none;
  logic word_elem = 1'b0;
  logic dflag = 1'b0;
  logic stack_load = 1'b0;
  logic [15:0] sval = 16'h0000;
  logic idx_load = 1'b0;
  logic [15:0] src_v = 16'h0000;
  logic [15:0] dst_v = 16'h0000;
  logic [15:0] io_addr = 16'h0000;
  logic addr_valid, lvh, rah, ioh;
  logic [19:0] phys_addr, last_addr;
  logic [15:0] fop, sto, ssi, sdi, seen;
  logic [15:0] segv [4];
  int fail_count = 0;
  int num_checks = 0;
  int nreq = 0;
  int cycles = 0;

  // fetch pointer loads stay tied; fetch stepping belongs to the prefetch path
  seg_addr_gen dut (.clk(clk), .nrst(nrst), .seg_wr(seg_wr), .seg_wr_sel(wsel),
    .seg_wr_data(wdata), .req(req), .ref_kind(kind), .override_valid(ovv),
    .override_seg(ovs), .computed_operand_offset(eoff), .ptr_op(pop),
    .word_elem(word_elem), .string_direction_flag(dflag), .fetch_advance(1'b0),
    .fetch_step(16'h0000), .fetch_load(1'b0), .fetch_load_value(16'h0000),
    .stack_load(stack_load), .stack_load_value(sval), .idx_load(idx_load),
    .src_idx_load_value(src_v), .dst_idx_load_value(dst_v), .io_addr(io_addr),
    .addr_valid(addr_valid), .phys_addr(phys_addr), .low_vector_hit(lvh),
    .reset_area_hit(rah), .io_reserved_hit(ioh), .fetch_offset_pointer(fop),
    .stack_top_offset(sto), .string_src_index(ssi), .string_dest_index(sdi));
  seg_bus_sink sink (.clk(clk), .nrst(nrst), .addr_valid(addr_valid),
    .phys_addr(phys_addr), .last_addr(last_addr), .seen_count(seen));

  always #20 clk = ~clk;

  // ****************************************
  // shared tasks
  // ****************************************
  function automatic logic [19:0] pa(input logic [15:0] s, input logic [15:0] o);
    return {s, 4'h0} + {4'h0, o};
  endfunction : pa

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic seg_load(input int s, input logic [15:0] v);
    @(posedge clk);
    seg_wr <= 1'b1;
    wsel <= seg_addr_pkg::seg_sel_t'(s);
    wdata <= v;
    @(posedge clk);
    seg_wr <= 1'b0;
    segv[s] = v;
  endtask : seg_load

  // address is flagged valid for one cycle, two edges after the edge that drives req, and holds after that
  task automatic do_req(input seg_addr_pkg::ref_kind_t k, input logic ov, input int os,
                        input logic [15:0] off, input seg_addr_pkg::ptr_op_t op,
                        input logic [19:0] exp);
    @(posedge clk);
    req <= 1'b1;
    kind <= k;
    ovv <= ov;
    ovs <= seg_addr_pkg::seg_sel_t'(os);
    eoff <= off;
    pop <= op;
    @(posedge clk);
    req <= 1'b0;
    ovv <= 1'b0;
    pop <= seg_addr_pkg::pop_none;
    @(posedge clk);
    #1;
    nreq++;
    chk({19'h0, addr_valid}, 20'h00001);
    chk(phys_addr, exp);
  endtask : do_req

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    #1;
    chk(phys_addr, 20'hffff0);
    chk({19'h0, rah}, 20'h00001);
    chk({4'h0, fop}, 20'h00000);
    do_req(seg_addr_pkg::ref_fetch, 1'b1, 3, 16'h0000, seg_addr_pkg::pop_none,
           pa(16'hffff, 16'h0000));
    do_req(seg_addr_pkg::ref_operand, 1'b0, 0, 16'h1234, seg_addr_pkg::pop_none,
           20'h01234);
  endtask : t_reset

  task automatic t_select;
    for (int s = 0; s < 4; s++) seg_load(s, 16'h1000 * (s + 1));
    for (int s = 0; s < 4; s++) begin
      do_req(seg_addr_pkg::ref_operand, 1'b1, s, 16'h8123, seg_addr_pkg::pop_none,
             pa(segv[s], 16'h8123));
      do_req(seg_addr_pkg::ref_frame, 1'b1, s, 16'h0456, seg_addr_pkg::pop_none,
             pa(segv[s], 16'h0456));
      do_req(seg_addr_pkg::ref_str_src, 1'b1, s, 16'h0000, seg_addr_pkg::pop_none,
             pa(segv[s], ssi));
      do_req(seg_addr_pkg::ref_str_dst, 1'b1, s, 16'h0000, seg_addr_pkg::pop_none,
             pa(segv[0], sdi));
      do_req(seg_addr_pkg::ref_stack, 1'b1, s, 16'h0000, seg_addr_pkg::pop_none,
             pa(segv[2], sto));
      do_req(seg_addr_pkg::ref_fetch, 1'b1, s, 16'h0000, seg_addr_pkg::pop_none,
             pa(segv[1], fop));
    end
    do_req(seg_addr_pkg::ref_operand, 1'b0, 0, 16'h0042, seg_addr_pkg::pop_none,
           pa(segv[3], 16'h0042));
    do_req(seg_addr_pkg::ref_frame, 1'b0, 0, 16'h0042, seg_addr_pkg::pop_none,
           pa(segv[2], 16'h0042));
  endtask : t_select

  task automatic t_stack;
    @(posedge clk);
    stack_load <= 1'b1;
    sval <= 16'h0000;
    @(posedge clk);
    stack_load <= 1'b0;
    do_req(seg_addr_pkg::ref_stack, 1'b0, 0, 16'h0000, seg_addr_pkg::pop_push,
           pa(segv[2], 16'hfffe));
    do_req(seg_addr_pkg::ref_stack, 1'b0, 0, 16'h0000, seg_addr_pkg::pop_push,
           pa(segv[2], 16'hfffc));
    chk({4'h0, sto}, 20'h0fffc);
    do_req(seg_addr_pkg::ref_stack, 1'b0, 0, 16'h0000, seg_addr_pkg::pop_pop,
           pa(segv[2], 16'hfffc));
    do_req(seg_addr_pkg::ref_stack, 1'b0, 0, 16'h0000, seg_addr_pkg::pop_pop,
           pa(segv[2], 16'hfffe));
    chk({4'h0, sto}, 20'h00000);
  endtask : t_stack

  task automatic t_string;
    logic [15:0] s;
    logic [15:0] d;
    s = 16'h0100;
    d = 16'h0001;
    @(posedge clk);
    idx_load <= 1'b1;
    src_v <= s;
    dst_v <= d;
    @(posedge clk);
    idx_load <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      dflag <= i[1];
      word_elem <= i[0];
      do_req(seg_addr_pkg::ref_str_src, 1'b0, 0, 16'h0000, seg_addr_pkg::pop_string,
             pa(segv[3], s));
      s = i[1] ? s - (i[0] ? 16'h2 : 16'h1) : s + (i[0] ? 16'h2 : 16'h1);
      d = i[1] ? d - (i[0] ? 16'h2 : 16'h1) : d + (i[0] ? 16'h2 : 16'h1);
      chk({4'h0, ssi}, {4'h0, s});
      chk({4'h0, sdi}, {4'h0, d});
    end
  endtask : t_string

  task automatic t_regions;
    logic [15:0] ports [4];
    ports = '{16'h00f7, 16'h00f8, 16'h00ff, 16'h0100};
    seg_load(3, 16'hffff);
    do_req(seg_addr_pkg::ref_operand, 1'b0, 0, 16'h0020, seg_addr_pkg::pop_none,
           20'h00010);
    seg_load(3, 16'h0000);
    do_req(seg_addr_pkg::ref_operand, 1'b0, 0, 16'h03ff, seg_addr_pkg::pop_none,
           20'h003ff);
    chk({19'h0, lvh}, 20'h00001);
    do_req(seg_addr_pkg::ref_operand, 1'b0, 0, 16'h0400, seg_addr_pkg::pop_none,
           20'h00400);
    chk({19'h0, lvh}, 20'h00000);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      io_addr <= ports[i];
      repeat (2) @(posedge clk);
      #1;
      chk({19'h0, ioh}, {19'h0, (i == 1 || i == 2)});
    end
  endtask : t_regions

  // ****************************************
  // run control
  // ****************************************
  // budget well above the roughly 160 cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    segv = '{16'h0000, 16'hffff, 16'h0000, 16'h0000};
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_select();
    t_stack();
    t_string();
    t_regions();
    repeat (2) @(posedge clk);
    chk({4'h0, seen}, nreq[19:0]);
    chk(last_addr, 20'h00400);
    close_out();
  end
endmodule : segment_address_generator_tb
`default_nettype wire
